// File: design/blanking_map.vh
`ifndef BLANKING_MAP_VH
`define BLANKING_MAP_VH

// beam geometry
`define BB_NUM_BEAMS 32
`define BB_MAX_REGIONS 6'h0A
`define BB_MIN_GAP_BEAMS 6'h01
`define BB_RED_RES_BEAMS 6'h02
`define BB_SYNC_FIRST 0
`define BB_SYNC_LAST 31

// core clock rate and operator timing
`define BB_CLK_KHZ 20000
`define BB_TEACH_MIN_MS 150
`define BB_TEACH_MAX_MS 4000
`define BB_CTL_WINDOW_MS 500
`define BB_FLASH_HALF_MS 250
// cycle counts are the ms figures times the clock rate in kHz,
// sized to the 27-bit timer width so no bits are dropped
`define BB_TEACH_MIN_CYC 27'h02DC6C0
`define BB_TEACH_MAX_CYC 27'h4C4B400
`define BB_CTL_WINDOW_CYC 27'h0989680
`define BB_FLASH_HALF_CYC 27'h04C4B40

// register byte offsets
`define BB_REG_CTRL 5'h00
`define BB_REG_STATUS 5'h04
`define BB_REG_FIXED_MASK 5'h08
`define BB_REG_FLOAT_MASK 5'h0C
`define BB_REG_BEAMS 5'h10

// control register fields and reset
`define BB_CTRL_MODE_LSB 0
`define BB_CTRL_FG1_BIT 3
`define BB_CTRL_MODE_RST 3'h1

// status register fields
`define BB_ST_TEACHING 0
`define BB_ST_BLANK_EN 1
`define BB_ST_OUTPUT_ON 2
`define BB_ST_SIZE_ERR 3
`define BB_ST_CONFIG_ERR 4
`define BB_ST_CTL_ERR 5
`define BB_ST_REGIONS_LSB 8

`endif

// File: design/beam_blanking_and_teach_control.v
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "blanking_map.vh"
`default_nettype none
module beam_blanking_and_teach_control #(
  parameter [26:0] TEACH_MIN_CYC = `BB_TEACH_MIN_CYC,
  parameter [26:0] TEACH_MAX_CYC = `BB_TEACH_MAX_CYC,
  parameter [26:0] CTL_WINDOW_CYC = `BB_CTL_WINDOW_CYC,
  parameter [26:0] FLASH_HALF_CYC = `BB_FLASH_HALF_CYC
) (
  // clock and reset
  input wire core_clk,
  input wire rstn,
  // avalon-mm slave
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // optical front end, same clock
  input wire [31:0] beam_blocked,
  input wire scan_done,
  // operator pins
  input wire teach_key,
  input wire blank_ctl_a,
  input wire blank_ctl_b,
  // outputs
  output reg safety_switching_output,
  output reg blanking_status_indicator,
  output reg teach_size_error_message
);

  localparam TS_IDLE = 1'b0;
  localparam TS_TEACH = 1'b1;
  localparam CS_IDLE = 1'b0;
  localparam CS_WAIT = 1'b1;

  function [5:0] popcount;
    input [31:0] v;
    integer i;
    begin
      popcount = 6'h00;
      for (i = 0; i < `BB_NUM_BEAMS; i = i + 1)
        popcount = popcount + {5'h00, v[i]};
    end
  endfunction

  function [5:0] region_count;
    input [31:0] v;
    integer i;
    reg prev;
    begin
      region_count = 6'h00;
      prev = 1'b0;
      for (i = 0; i < `BB_NUM_BEAMS; i = i + 1) begin
        if (v[i] && !prev)
          region_count = region_count + 6'h01;
        prev = v[i];
      end
    end
  endfunction

  // 1 when every gap between two regions is at least BB_MIN_GAP_BEAMS
  function gap_ok;
    input [31:0] v;
    integer i;
    reg seen;
    reg [5:0] gap;
    begin
      gap_ok = 1'b1;
      seen = 1'b0;
      gap = 6'h00;
      for (i = 0; i < `BB_NUM_BEAMS; i = i + 1) begin
        if (v[i]) begin
          if (seen && gap != 6'h00 && gap < `BB_MIN_GAP_BEAMS)
            gap_ok = 1'b0;
          seen = 1'b1;
          gap = 6'h00;
        end else if (seen) begin
          gap = gap + 6'h01;
        end
      end
    end
  endfunction

  function [5:0] max_run;
    input [31:0] v;
    integer i;
    reg [5:0] run;
    begin
      max_run = 6'h00;
      run = 6'h00;
      for (i = 0; i < `BB_NUM_BEAMS; i = i + 1) begin
        run = v[i] ? run + 6'h01 : 6'h00;
        if (run > max_run)
          max_run = run;
      end
    end
  endfunction

  // pin synchronisers; first stages feed only second stages
  reg [2:0] pin_meta_ff;
  reg [2:0] pin_sync_ff;
  reg key_prev_ff;
  reg [1:0] ctl_prev_ff;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta_ff <= 3'h0;
      pin_sync_ff <= 3'h0;
      key_prev_ff <= 1'b0;
      ctl_prev_ff <= 2'h0;
    end else begin
      pin_meta_ff <= {blank_ctl_b, blank_ctl_a, teach_key};
      pin_sync_ff <= pin_meta_ff;
      key_prev_ff <= pin_sync_ff[0];
      ctl_prev_ff <= pin_sync_ff[2:1];
    end
  end
  wire key_now = pin_sync_ff[0];
  wire [1:0] ctl_now = pin_sync_ff[2:1];

  // register state
  reg [2:0] op_mode_ff;
  reg fg1_ff;
  reg config_err_ff;
  reg ctl_err_ff;
  wire mode_tol = (op_mode_ff == 3'h4) || (op_mode_ff == 3'h6);
  wire mode_ctl = (op_mode_ff == 3'h1) || (op_mode_ff == 3'h3);

  // teach key press timing
  reg [26:0] key_cnt_ff;
  wire key_release = key_prev_ff && !key_now;
  wire key_valid = key_release && key_cnt_ff >= TEACH_MIN_CYC &&
    key_cnt_ff <= TEACH_MAX_CYC;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      key_cnt_ff <= 27'h0000000;
    else if (!key_now)
      key_cnt_ff <= 27'h0000000;
    else if (key_cnt_ff <= TEACH_MAX_CYC)
      key_cnt_ff <= key_cnt_ff + 27'h0000001;
  end

  // teach sequence: and-mask keeps always-blocked beams (fixed),
  // or-mask keeps the whole area any object passed (floating)
  reg teach_state_ff;
  reg teach_first_ff;
  reg [31:0] and_mask_ff;
  reg [31:0] or_mask_ff;
  reg [5:0] ref_size_ff;
  reg [31:0] fixed_mask_ff;
  reg [31:0] float_mask_ff;
  reg size_err_ff;
  wire [5:0] scan_size = popcount(beam_blocked);
  wire size_bad = scan_size > ref_size_ff + 6'h01 ||
    ref_size_ff > scan_size + 6'h01;
  wire [31:0] new_fixed = teach_first_ff ? 32'h00000000 : and_mask_ff;
  wire [31:0] new_float = or_mask_ff & ~new_fixed;
  wire [5:0] new_fix_regions = region_count(new_fixed);
  wire [5:0] new_flt_regions = region_count(new_float);
  wire new_ok = new_fix_regions <= `BB_MAX_REGIONS &&
    new_flt_regions <= `BB_MAX_REGIONS &&
    !(or_mask_ff[`BB_SYNC_FIRST] && or_mask_ff[`BB_SYNC_LAST]) &&
    gap_ok(or_mask_ff);
  wire st_clear_size;
  wire st_clear_cfg;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      teach_state_ff <= TS_IDLE;
      teach_first_ff <= 1'b1;
      and_mask_ff <= 32'hFFFFFFFF;
      or_mask_ff <= 32'h00000000;
      ref_size_ff <= 6'h00;
      fixed_mask_ff <= 32'h00000000;
      float_mask_ff <= 32'h00000000;
      size_err_ff <= 1'b0;
      config_err_ff <= 1'b0;
    end else begin
      if (st_clear_size)
        size_err_ff <= 1'b0;
      if (st_clear_cfg)
        config_err_ff <= 1'b0;
      case (teach_state_ff)
        TS_IDLE: begin
          if (key_valid) begin
            teach_state_ff <= TS_TEACH;
            teach_first_ff <= 1'b1;
            and_mask_ff <= 32'hFFFFFFFF;
            or_mask_ff <= 32'h00000000;
          end
        end
        TS_TEACH: begin
          if (scan_done && !teach_first_ff && size_bad) begin
            teach_state_ff <= TS_IDLE;
            size_err_ff <= 1'b1;
          end else if (key_valid) begin
            teach_state_ff <= TS_IDLE;
            if (new_ok) begin
              fixed_mask_ff <= new_fixed;
              float_mask_ff <= new_float;
            end else begin
              config_err_ff <= 1'b1;
            end
          end else if (scan_done) begin
            teach_first_ff <= 1'b0;
            if (teach_first_ff)
              ref_size_ff <= scan_size;
            and_mask_ff <= and_mask_ff & beam_blocked;
            or_mask_ff <= or_mask_ff | beam_blocked;
          end
        end
        default: teach_state_ff <= TS_IDLE;
      endcase
    end
  end

  // two-channel complementary switch sequence
  reg ctl_state_ff;
  reg [1:0] ctl_target_ff;
  reg [26:0] ctl_cnt_ff;
  reg blank_en_ff;
  wire st_clear_ctl;
  wire ctl_compl = ctl_prev_ff[0] != ctl_prev_ff[1];
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctl_state_ff <= CS_IDLE;
      ctl_target_ff <= 2'h0;
      ctl_cnt_ff <= 27'h0000000;
      blank_en_ff <= 1'b0;
      ctl_err_ff <= 1'b0;
    end else begin
      if (st_clear_ctl)
        ctl_err_ff <= 1'b0;
      case (ctl_state_ff)
        CS_IDLE: begin
          ctl_cnt_ff <= 27'h0000000;
          if (ctl_compl && ctl_now == ~ctl_prev_ff) begin
            blank_en_ff <= ctl_now[0];
          end else if (ctl_compl && ctl_now != ctl_prev_ff) begin
            ctl_state_ff <= CS_WAIT;
            ctl_target_ff <= ~ctl_prev_ff;
          end
        end
        CS_WAIT: begin
          ctl_cnt_ff <= ctl_cnt_ff + 27'h0000001;
          if (ctl_now == ctl_target_ff) begin
            ctl_state_ff <= CS_IDLE;
            blank_en_ff <= ctl_target_ff[0];
          end else if (ctl_cnt_ff >= CTL_WINDOW_CYC) begin
            ctl_state_ff <= CS_IDLE;
            ctl_err_ff <= 1'b1;
          end
        end
        default: ctl_state_ff <= CS_IDLE;
      endcase
    end
  end

  // per-scan evaluation of the protective field
  wire blanking_on = !mode_ctl || blank_en_ff;
  wire float_on = blanking_on && op_mode_ff == 3'h3 &&
    float_mask_ff != 32'h00000000;
  wire red_res_on = float_on ||
    (op_mode_ff == 3'h3 && fg1_ff);
  wire [31:0] fix_act = blanking_on ? fixed_mask_ff : 32'h00000000;
  wire [31:0] fix_zone = mode_tol ?
    (fix_act | (fix_act << 1) | (fix_act >> 1)) :
    fix_act;
  wire [31:0] flt_zone = float_on ? float_mask_ff : 32'h00000000;
  wire fix_present = mode_tol ?
    popcount(beam_blocked & fix_zone) >= popcount(fix_act) :
    (beam_blocked & fix_act) == fix_act;
  wire flt_present = !float_on ||
    (beam_blocked & flt_zone) != 32'h00000000;
  wire [31:0] violation = beam_blocked & ~fix_zone & ~flt_zone;
  // reduced resolution only bounds object width, never counts objects
  wire field_ok = red_res_on ?
    max_run(violation) <= `BB_RED_RES_BEAMS :
    violation == 32'h00000000;
  wire output_on = teach_state_ff == TS_IDLE && field_ok &&
    fix_present && flt_present;

  // indicator flash timebase
  reg [26:0] flash_cnt_ff;
  reg flash_ff;
  reg [31:0] beams_ff;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flash_cnt_ff <= 27'h0000000;
      flash_ff <= 1'b0;
      beams_ff <= 32'h00000000;
      safety_switching_output <= 1'b0;
      blanking_status_indicator <= 1'b0;
      teach_size_error_message <= 1'b0;
    end else begin
      if (flash_cnt_ff >= FLASH_HALF_CYC - 27'h0000001) begin
        flash_cnt_ff <= 27'h0000000;
        flash_ff <= ~flash_ff;
      end else begin
        flash_cnt_ff <= flash_cnt_ff + 27'h0000001;
      end
      if (scan_done) begin
        beams_ff <= beam_blocked;
        safety_switching_output <= output_on;
      end else if (teach_state_ff == TS_TEACH) begin
        safety_switching_output <= 1'b0;
      end
      if (teach_state_ff == TS_TEACH)
        blanking_status_indicator <= flash_ff;
      else
        blanking_status_indicator <= blanking_on &&
          (fixed_mask_ff | float_mask_ff) != 32'h00000000;
      teach_size_error_message <= size_err_ff;
    end
  end

  // avalon slave: one wait state, write lands when waitrequest is low
  wire bus_req = avs_read || avs_write;
  wire bus_wr = avs_write && !avs_waitrequest;
  wire sel_status = avs_address == `BB_REG_STATUS;
  assign st_clear_size = bus_wr && sel_status && avs_byteenable[0] &&
    avs_writedata[`BB_ST_SIZE_ERR] && !(scan_done && size_bad &&
    teach_state_ff == TS_TEACH && !teach_first_ff);
  assign st_clear_cfg = bus_wr && sel_status && avs_byteenable[0] &&
    avs_writedata[`BB_ST_CONFIG_ERR];
  assign st_clear_ctl = bus_wr && sel_status && avs_byteenable[0] &&
    avs_writedata[`BB_ST_CTL_ERR];

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (avs_address)
      `BB_REG_CTRL: begin
        rd_mux[`BB_CTRL_MODE_LSB +: 3] = op_mode_ff;
        rd_mux[`BB_CTRL_FG1_BIT] = fg1_ff;
      end
      `BB_REG_STATUS: begin
        rd_mux[`BB_ST_TEACHING] = teach_state_ff;
        rd_mux[`BB_ST_BLANK_EN] = blanking_on;
        rd_mux[`BB_ST_OUTPUT_ON] = safety_switching_output;
        rd_mux[`BB_ST_SIZE_ERR] = size_err_ff;
        rd_mux[`BB_ST_CONFIG_ERR] = config_err_ff;
        rd_mux[`BB_ST_CTL_ERR] = ctl_err_ff;
        rd_mux[`BB_ST_REGIONS_LSB +: 6] =
          region_count(fixed_mask_ff | float_mask_ff);
      end
      `BB_REG_FIXED_MASK: rd_mux = fixed_mask_ff;
      `BB_REG_FLOAT_MASK: rd_mux = float_mask_ff;
      `BB_REG_BEAMS: rd_mux = beams_ff;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      op_mode_ff <= `BB_CTRL_MODE_RST;
      fg1_ff <= 1'b0;
    end else begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
      if (avs_read && avs_waitrequest)
        avs_readdata <= rd_mux;
      if (bus_wr && avs_address == `BB_REG_CTRL && avs_byteenable[0]) begin
        op_mode_ff <= avs_writedata[`BB_CTRL_MODE_LSB +: 3];
        fg1_ff <= avs_writedata[`BB_CTRL_FG1_BIT];
      end
    end
  end

endmodule // beam_blanking_and_teach_control
`default_nettype wire

// File: test/blanking_checker.sv
`timescale 1ns/1ps
`default_nettype none
module blanking_checker #(
  parameter [26:0] TEACH_MIN_CYC = 27'd20,
  parameter [26:0] TEACH_MAX_CYC = 27'd200,
  parameter [26:0] FLASH_HALF_CYC = 27'd8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // register bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // field and operator pins
  input wire logic scan_done,
  input wire logic teach_key,
  input wire logic blank_ctl_a,
  input wire logic blank_ctl_b,
  // outputs
  input wire logic safety_switching_output,
  input wire logic blanking_status_indicator,
  input wire logic teach_size_error_message
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic key_ff, ind_ff, err_ff, teach_ff;
  logic [1:0] ctl_ff;
  logic [26:0] hold_ff;
  logic [7:0] age_ff, still_ff, quiet_ff;
  // teach state rebuilt from the key alone; a size abort ends it
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      key_ff <= 1'b0;
      ind_ff <= 1'b0;
      err_ff <= 1'b0;
      teach_ff <= 1'b0;
      ctl_ff <= 2'h0;
      hold_ff <= 27'h0;
      age_ff <= 8'h0;
      still_ff <= 8'h0;
      quiet_ff <= 8'h0;
    end else begin
      key_ff <= teach_key;
      ind_ff <= blanking_status_indicator;
      err_ff <= teach_size_error_message;
      ctl_ff <= {blank_ctl_a, blank_ctl_b};
      hold_ff <= teach_key ? hold_ff + 27'h1 : 27'h0;
      if (key_ff && !teach_key && hold_ff >= TEACH_MIN_CYC &&
          hold_ff <= TEACH_MAX_CYC)
        teach_ff <= !teach_ff;
      else if (teach_size_error_message && !err_ff)
        teach_ff <= 1'b0;
      age_ff <= !teach_ff ? 8'h0 : age_ff + {7'h0, age_ff != 8'hFF};
      still_ff <= (blanking_status_indicator != ind_ff) ? 8'h0 :
        still_ff + {7'h0, still_ff != 8'hFF};
      // any cause that may legally move the indicator restarts the count
      quiet_ff <= (teach_ff || avs_write ||
        ctl_ff != {blank_ctl_a, blank_ctl_b}) ? 8'h0 :
        quiet_ff + {7'h0, quiet_ff != 8'hFF};
    end
  end
  wait_one_cycle_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("request not answered next cycle");
  unmapped_read_a: assert property (avs_read && avs_waitrequest &&
    avs_address > 5'h10 |=> avs_readdata == 32'h0)
    else $error("unmapped read returned data");
  output_on_scan_a: assert property (
    !$stable(safety_switching_output) |-> $past(scan_done))
    else $error("safety output changed without a scan");
  flash_teach_a: assert property (
    age_ff > 8'h18 |-> still_ff <= FLASH_HALF_CYC[7:0] + 8'h2)
    else $error("indicator not flashing while teaching");
  size_err_teach_a: assert property (
    $rose(teach_size_error_message) |-> $past(teach_ff, 4))
    else $error("size error raised outside teaching");
  err_clear_a: assert property (
    $fell(teach_size_error_message) |-> $past(avs_write, 2))
    else $error("size error dropped without a write");
  quiet_ind_a: assert property (
    quiet_ff > 8'h8 |-> $stable(blanking_status_indicator))
    else $error("indicator moved without a cause");
endmodule // blanking_checker
bind beam_blanking_and_teach_control blanking_checker #(
  .TEACH_MIN_CYC(TEACH_MIN_CYC),
  .TEACH_MAX_CYC(TEACH_MAX_CYC),
  .FLASH_HALF_CYC(FLASH_HALF_CYC)
) checker_i (.core_clk, .rstn, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .scan_done, .teach_key, .blank_ctl_a,
  .blank_ctl_b, .safety_switching_output, .blanking_status_indicator,
  .teach_size_error_message);
`default_nettype wire

// File: test/operator_panel.sv
`timescale 1ns/1ps
`default_nettype none
module operator_panel (
  // clock
  input wire logic clk,
  // operator pins
  output logic key,
  output logic ctl_a,
  output logic ctl_b
);
  initial begin
    key = 1'b0;
    ctl_a = 1'b1;
    ctl_b = 1'b0;
  end
  // hold the key n cycles, then leave time for the synchronizer
  task automatic press(input int n);
    key <= 1'b1;
    repeat (n) @(posedge clk);
    key <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // channel b follows channel a after gap cycles
  task automatic flip(input int gap);
    ctl_a <= ~ctl_a;
    repeat (gap) @(posedge clk);
    ctl_b <= ~ctl_b;
    repeat (6) @(posedge clk);
  endtask
endmodule // operator_panel
`default_nettype wire

// File: test/tb_beam_blanking_and_teach_control.sv
`timescale 1ns/1ps
`include "blanking_map.vh"
`default_nettype none
module tb_beam_blanking_and_teach_control;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  localparam logic [26:0] MIN_HOLD = 27'h14;
  localparam logic [26:0] MAX_HOLD = 27'hC8;
  localparam logic [26:0] CTL_WIN = 27'h32;
  localparam logic [26:0] FLASH_HALF = 27'h8;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] beam_blocked = 32'h0;
  logic scan_done = 1'b0;
  logic [31:0] avs_readdata, q, f;
  logic avs_waitrequest, safe_out, ind, size_msg;
  logic teach_key, blank_ctl_a, blank_ctl_b;
  int err_total = 0;
  int compares = 0;
  int hold[2] = '{5, 300};
  logic [4:0] ro[3] = '{`BB_REG_FIXED_MASK, `BB_REG_FLOAT_MASK, 5'h14};
  logic [2:0] om[6] = '{3'h2, 3'h2, 3'h2, 3'h4, 3'h4, 3'h4};
  logic [31:0] op[6] = '{32'h70, 32'h0, 32'hE0, 32'hE0, 32'h1F0, 32'h0};
  logic oe[6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  // mode 3 without and with function group one, then with floating blanking
  logic [31:0] rm[7] = '{32'h3, 32'hB, 32'hB, 32'h3, 32'h3, 32'h3, 32'h3};
  logic [31:0] rp[7] = '{32'h1870, 32'h1870, 32'h3870, 32'hF0, 32'h70,
    32'h18F0, 32'h38F0};
  logic re[7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic [31:0] cp[5] = '{32'h80000001, 32'h2AAAAA, 32'hAAAAA, 32'h0, 32'h70};
  logic ca[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  int cg[4] = '{80, 2, 2, 2};
  logic [31:0] cm[4] = '{32'h20, 32'h2, 32'h2, 32'h2};
  logic [31:0] ce[4] = '{32'h20, 32'h2, 32'h0, 32'h2};
  always #25 core_clk = ~core_clk;
  beam_blanking_and_teach_control #(.TEACH_MIN_CYC(MIN_HOLD),
    .TEACH_MAX_CYC(MAX_HOLD), .CTL_WINDOW_CYC(CTL_WIN),
    .FLASH_HALF_CYC(FLASH_HALF)) dut (.core_clk(core_clk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .beam_blocked(beam_blocked), .scan_done(scan_done),
    .teach_key(teach_key), .blank_ctl_a(blank_ctl_a),
    .blank_ctl_b(blank_ctl_b), .safety_switching_output(safe_out),
    .blanking_status_indicator(ind), .teach_size_error_message(size_msg));
  operator_panel panel (.clk(core_clk), .key(teach_key),
    .ctl_a(blank_ctl_a), .ctl_b(blank_ctl_b));
  function automatic logic [5:0] runs(input logic [31:0] p);
    return 6'($countones(p & ~(p << 1)));
  endfunction
  task automatic complete_run();
    if (err_total == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      err_total++;
      complete_run();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rchk(input string nm, input logic [4:0] a,
                      input logic [31:0] m, e);
    bus(1'b0, a, 32'h0);
    check(nm, q & m, e);
  endtask
  task automatic scan(input logic [31:0] b);
    beam_blocked <= b;
    scan_done <= 1'b1;
    @(posedge core_clk);
    scan_done <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic teach(input logic [31:0] p0, p1, input logic fin);
    panel.press(100);
    rchk("teaching", `BB_REG_STATUS, 32'h1, 32'h1);
    scan(p0);
    scan(p1);
    if (fin)
      panel.press(100);
  endtask
  initial begin
    void'($urandom(32'h46FA0D5F));
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    check("out", {31'h0, safe_out}, 32'h0);
    rchk("ctrl", `BB_REG_CTRL, '1, 32'h1);
    rchk("status", `BB_REG_STATUS, '1, 32'h0);
    // a control write without lane 0 must leave the mode alone
    avs_byteenable <= 4'hE;
    bus(1'b1, `BB_REG_CTRL, 32'h2);
    avs_byteenable <= 4'hF;
    rchk("ctrl lane", `BB_REG_CTRL, '1, 32'h1);
    foreach (ro[i]) begin
      bus(1'b1, ro[i], '1);
      rchk("read only", ro[i], '1, 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      f = (i == 0) ? 32'h0 : $urandom;
      scan(f);
      rchk("beams", `BB_REG_BEAMS, '1, f);
      check("out", {31'h0, safe_out}, {31'h0, f == 0});
    end
    foreach (hold[i]) begin
      panel.press(hold[i]);
      rchk("no teach", `BB_REG_STATUS, 32'h1, 32'h0);
    end
    bus(1'b1, `BB_REG_CTRL, 32'h2);
    teach(32'h70, 32'hF0, 1'b1);
    rchk("fixed", `BB_REG_FIXED_MASK, '1, 32'h70);
    foreach (om[i]) begin
      bus(1'b1, `BB_REG_CTRL, {29'h0, om[i]});
      scan(op[i]);
      check("out", {31'h0, safe_out}, {31'h0, oe[i]});
    end
    bus(1'b1, `BB_REG_CTRL, 32'h2);
    teach(32'h70, 32'h3F0, 1'b0);
    repeat (4) @(posedge core_clk);
    check("size msg", {31'h0, size_msg}, 32'h1);
    rchk("abort", `BB_REG_STATUS, 32'h9, 32'h8);
    bus(1'b1, `BB_REG_STATUS, 32'h8);
    @(posedge core_clk);
    check("size msg", {31'h0, size_msg}, 32'h0);
    f = 32'h70;
    foreach (cp[i]) begin
      teach(cp[i], cp[i], 1'b1);
      if (ca[i])
        f = cp[i];
      rchk("fixed", `BB_REG_FIXED_MASK, '1, f);
      rchk("status", `BB_REG_STATUS, 32'h3F11,
        {18'h0, runs(f), 3'h0, !ca[i], 4'h0});
      check("ind", {31'h0, ind}, {31'h0, f != 0});
      bus(1'b1, `BB_REG_STATUS, 32'h10);
    end
    bus(1'b1, `BB_REG_CTRL, 32'h1);
    foreach (cg[i]) begin
      panel.flip(cg[i]);
      rchk("control", `BB_REG_STATUS, cm[i], ce[i]);
    end
    check("ind", {31'h0, ind}, 32'h1);
    scan(32'h70);
    check("out", {31'h0, safe_out}, 32'h1);
    scan(32'h0);
    check("out", {31'h0, safe_out}, 32'h0);
    foreach (rm[i]) begin
      if (i == 3)
        teach(32'h70, 32'hF0, 1'b1);
      bus(1'b1, `BB_REG_CTRL, rm[i]);
      scan(rp[i]);
      check("out", {31'h0, safe_out}, {31'h0, re[i]});
    end
    panel.flip(2);
    rchk("control", `BB_REG_STATUS, 32'h2, 32'h0);
    scan(32'h0);
    check("out", {31'h0, safe_out}, 32'h1);
    check("ind", {31'h0, ind}, 32'h0);
    complete_run();
  end
endmodule // tb_beam_blanking_and_teach_control
`default_nettype wire
